// ---- hdl/rtod_regs.v ----
// Purpose: Time-of-day column registers with seconds counting, AHB-Lite slave
// Assumes: Software writes only valid BCD; single word transfers
// Notes:   Zero wait states; count fields undefined until written
//
// Implementation choices: the register offsets and the AHB-Lite slave port.
`timescale 1ns/1ps
`include "rtod_defines.vh"
module rtod_regs #(
  parameter TICK_CYC = `RTOD_TICK_CYC
) (
  // Clock and reset
  input  wire        SYS_CLK_IN,
  input  wire        RST_IN,
  input  wire        CLK_EN_IN,
  // AHB-Lite slave
  input  wire        HSEL_IN,
  input  wire [31:0] HADDR_IN,
  input  wire [1:0]  HTRANS_IN,
  input  wire        HWRITE_IN,
  input  wire [2:0]  HSIZE_IN,
  input  wire        HREADY_IN,
  input  wire [31:0] HWDATA_IN,
  output reg  [31:0] HRDATA_OUT,
  output wire        HREADYOUT_OUT,
  output wire        HRESP_OUT,
  // Status
  output wire        HOUR_FORMAT_SELECT_OUT,
  output wire        TICK_OUT
);
  reg  [6:0]  sec_r;
  reg  [6:0]  min_r;
  reg  [5:0]  hour_r;
  reg  [2:0]  day_r;
  reg         hour_format_select_r;
  reg         run_r;
  reg         page_r;
  reg  [25:0] pre_r;
  reg         tick_r;
  reg         wr_pend_r;
  reg  [3:0]  wr_idx_r;
  wire        acc;
  wire [3:0]  a_idx;
  wire [6:0]  sec_nxt;
  wire [6:0]  min_nxt;
  wire        sec_cy;
  wire        min_cy;
  wire [6:0]  h24_nxt;
  wire        h24_cy;
  wire [6:0]  h12_nxt;
  wire        h12_cy;
  reg  [5:0]  hour_nxt;
  reg         hour_cy;
  wire [2:0]  day_nxt;
  wire        wr_sec;
  wire        wr_min;
  wire        wr_hour;
  wire        wr_day;
  wire        wr_fmt;
  wire        wr_ctrl;

  function [3:0] idx_of;
    input [31:0] a;
    begin
      idx_of = (a[31:6] == 26'h0) ? a[5:2] : 4'hf;
    end
  endfunction

  // Write decode shared by every register
  function wr_hit;
    input       pend;
    input [3:0] cur;
    input [3:0] idx;
    begin
      wr_hit = pend & (cur == idx);
    end
  endfunction

  assign acc           = HSEL_IN & HREADY_IN & HTRANS_IN[1];
  assign a_idx         = idx_of(HADDR_IN);
  assign HREADYOUT_OUT = 1'b1;
  assign HRESP_OUT     = 1'b0;
  assign HOUR_FORMAT_SELECT_OUT = hour_format_select_r;
  assign TICK_OUT      = tick_r;

  assign wr_sec  = wr_hit(wr_pend_r, wr_idx_r, `RTOD_IDX_SEC) & ~page_r;
  assign wr_min  = wr_hit(wr_pend_r, wr_idx_r, `RTOD_IDX_MIN);
  assign wr_hour = wr_hit(wr_pend_r, wr_idx_r, `RTOD_IDX_HOUR);
  assign wr_day  = wr_hit(wr_pend_r, wr_idx_r, `RTOD_IDX_DAY);
  assign wr_fmt  = wr_hit(wr_pend_r, wr_idx_r, `RTOD_IDX_FMT) & page_r;
  assign wr_ctrl = wr_hit(wr_pend_r, wr_idx_r, `RTOD_IDX_CTRL);

  rtod_bcd_inc u_sec (
    .val_in    (sec_r),
    .max_in    (`RTOD_SEC_MAX),
    .wrap_in   (7'h00),
    .nxt_out   (sec_nxt),
    .carry_out (sec_cy)
  );
  rtod_bcd_inc u_min (
    .val_in    (min_r),
    .max_in    (`RTOD_MIN_MAX),
    .wrap_in   (7'h00),
    .nxt_out   (min_nxt),
    .carry_out (min_cy)
  );
  rtod_bcd_inc u_h24 (
    .val_in    ({1'b0, hour_r}),
    .max_in    ({1'b0, `RTOD_H24_MAX}),
    .wrap_in   (7'h00),
    .nxt_out   (h24_nxt),
    .carry_out (h24_cy)
  );
  rtod_bcd_inc u_h12 (
    .val_in    ({2'b00, hour_r[4:0]}),
    .max_in    ({2'b00, `RTOD_H12_MAX}),
    .wrap_in   (7'h00),
    .nxt_out   (h12_nxt),
    .carry_out (h12_cy)
  );

  // 12-hour wrap toggles AM/PM; day advances after 11 PM
  always @* begin
    if (hour_format_select_r) begin
      hour_nxt = h24_nxt[5:0];
      hour_cy  = h24_cy;
    end else begin
      hour_nxt = {h12_cy ^ hour_r[`RTOD_PM_BIT], h12_nxt[4:0]};
      hour_cy  = h12_cy & hour_r[`RTOD_PM_BIT];
    end
  end

  assign day_nxt = (day_r == `RTOD_DAY_MAX) ? 3'h0 : day_r + 3'h1;

  // One-second prescaler
  always @(posedge SYS_CLK_IN) begin
    if (RST_IN) begin
      pre_r  <= 26'h0;
      tick_r <= 1'b0;
    end else if (CLK_EN_IN) begin
      tick_r <= 1'b0;
      if (!run_r) begin
        pre_r <= 26'h0;
      end else if (pre_r == TICK_CYC - 1) begin
        pre_r  <= 26'h0;
        tick_r <= 1'b1;
      end else begin
        pre_r <= pre_r + 26'h1;
      end
    end
  end

  // Bus address phase capture
  always @(posedge SYS_CLK_IN) begin
    if (RST_IN) begin
      wr_pend_r <= 1'b0;
      wr_idx_r  <= 4'h0;
    end else if (CLK_EN_IN) begin
      wr_pend_r <= acc & HWRITE_IN;
      wr_idx_r  <= a_idx;
    end
  end

  // Format and control bits; format only while page_r is set
  always @(posedge SYS_CLK_IN) begin
    if (RST_IN) begin
      hour_format_select_r <= 1'b0;
      run_r                <= 1'b0;
      page_r               <= 1'b0;
    end else if (CLK_EN_IN) begin
      if (wr_fmt)
        hour_format_select_r <= HWDATA_IN[0];
      if (wr_ctrl) begin
        run_r  <= HWDATA_IN[`RTOD_CTRL_RUN_BIT];
        page_r <= HWDATA_IN[`RTOD_CTRL_PG_BIT];
      end
    end
  end

  // Counters; a software write takes priority over the tick
  always @(posedge SYS_CLK_IN) begin
    if (CLK_EN_IN) begin
      if (wr_sec)
        sec_r <= HWDATA_IN[6:0];
      else if (tick_r)
        sec_r <= sec_nxt;
      if (wr_min)
        min_r <= HWDATA_IN[6:0];
      else if (tick_r && sec_cy)
        min_r <= min_nxt;
      if (wr_hour)
        hour_r <= HWDATA_IN[5:0];
      else if (tick_r && sec_cy && min_cy)
        hour_r <= hour_nxt;
      if (wr_day)
        day_r <= HWDATA_IN[2:0];
      else if (tick_r && sec_cy && min_cy && hour_cy)
        day_r <= day_nxt;
    end
  end

  // Read data registered at the address phase, zero wait
  always @(posedge SYS_CLK_IN) begin
    if (RST_IN) begin
      HRDATA_OUT <= 32'h0;
    end else if (CLK_EN_IN) begin
      HRDATA_OUT <= 32'h0;
      if (acc && !HWRITE_IN) begin
        case (a_idx)
          `RTOD_IDX_SEC:  HRDATA_OUT <= page_r ? 32'h0 : {25'h0, sec_r};
          `RTOD_IDX_MIN:  HRDATA_OUT <= {25'h0, min_r};
          `RTOD_IDX_HOUR: HRDATA_OUT <= {26'h0, hour_r};
          `RTOD_IDX_DAY:  HRDATA_OUT <= {29'h0, day_r};
          `RTOD_IDX_FMT:  HRDATA_OUT <= {31'h0, page_r & hour_format_select_r};
          `RTOD_IDX_CTRL: HRDATA_OUT <= {28'h0, run_r, 2'b00, page_r};
          default:        HRDATA_OUT <= 32'h0;
        endcase
      end
    end
  end
endmodule // rtod_regs

// ---- hdl/rtod_defines.vh ----
// Purpose: Constants for the time-of-day column registers
// Assumes: Word-aligned AHB-Lite register map, 40 MHz clock
// Notes:   Count fields hold BCD
`ifndef RTOD_DEFINES_VH
`define RTOD_DEFINES_VH
`define RTOD_IDX_SEC      4'h0
`define RTOD_IDX_MIN      4'h1
`define RTOD_IDX_HOUR     4'h2
`define RTOD_IDX_DAY      4'h4
`define RTOD_IDX_FMT      4'h6
`define RTOD_IDX_CTRL     4'h8
`define RTOD_CLK_HZ       40000000
`define RTOD_TICK_CYC     40000000
`define RTOD_SEC_MAX      7'h59
`define RTOD_MIN_MAX      7'h59
`define RTOD_H24_MAX      6'h23
`define RTOD_H12_MAX      5'h11
`define RTOD_DAY_MAX      3'h6
`define RTOD_PM_BIT       5
`define RTOD_CTRL_RUN_BIT 3
`define RTOD_CTRL_PG_BIT  0
`endif

// ---- hdl/rtod_bcd_inc.v ----
// Purpose: BCD increment of a two-digit count with wrap
// Assumes: Input is valid BCD not above max
// Notes:   Carry is high when the count is at max and wraps to wrap_in
`timescale 1ns/1ps
module rtod_bcd_inc (
  // Count
  input  wire [6:0] val_in,
  input  wire [6:0] max_in,
  input  wire [6:0] wrap_in,
  // Result
  output wire [6:0] nxt_out,
  output wire       carry_out
);
  wire       at_max;
  wire [3:0] units_p1;
  wire [2:0] tens_p1;
  assign at_max    = (val_in == max_in);
  assign units_p1  = val_in[3:0] + 4'h1;
  assign tens_p1   = val_in[6:4] + 3'h1;
  assign carry_out = at_max;
  assign nxt_out   = at_max ? wrap_in :
                     (val_in[3:0] == 4'h9) ? {tens_p1, 4'h0} :
                     {val_in[6:4], units_p1};
endmodule // rtod_bcd_inc

// ---- tb/rtod_regs_properties.sv ----
// Purpose: Port assertions for rtod_regs
// Assumes: Word accesses, zero wait states
// Notes:   Bound to every rtod_regs
`timescale 1ns/1ps
module rtod_props (
  input wire        SYS_CLK_IN,
  input wire        RST_IN,
  input wire        CLK_EN_IN,
  input wire        HSEL_IN,
  input wire [31:0] HADDR_IN,
  input wire [1:0]  HTRANS_IN,
  input wire        HWRITE_IN,
  input wire        HREADY_IN,
  input wire [31:0] HRDATA_OUT,
  input wire        HREADYOUT_OUT,
  input wire        HRESP_OUT,
  input wire        HOUR_FORMAT_SELECT_OUT,
  input wire        TICK_OUT
);
  wire      take = HSEL_IN & HREADY_IN & HTRANS_IN[1] & CLK_EN_IN;
  reg       rd_r;
  reg       wf_r;
  reg [7:0] ad_r;
  // Data phase tracking freezes with the design
  always @(posedge SYS_CLK_IN) begin
    if (CLK_EN_IN) begin
      rd_r <= take & ~HWRITE_IN;
      wf_r <= take & HWRITE_IN & (HADDR_IN[7:0] == 8'h18);
      ad_r <= HADDR_IN[7:0];
    end
  end
  default clocking @(posedge SYS_CLK_IN); endclocking
  default disable iff (RST_IN);
  resp_okay_a: assert property (HRESP_OUT == 1'b0 && HREADYOUT_OUT == 1'b1)
    else $error("bad bus response");
  rdata_idle_a: assert property (!rd_r |-> HRDATA_OUT == 32'h0)
    else $error("read data outside data phase");
  sec_min_a: assert property (rd_r && ad_r <= 8'h04 |-> HRDATA_OUT[31:7] == 25'h0 &&
    HRDATA_OUT[3:0] <= 4'h9 && HRDATA_OUT[6:4] <= 3'h5) else $error("bad sec or min");
  hour_upper_a: assert property (rd_r && ad_r == 8'h08 |-> HRDATA_OUT[31:6] == 26'h0)
    else $error("hour upper bits set");
  hour_12h_a: assert property (rd_r && ad_r == 8'h08 && !HOUR_FORMAT_SELECT_OUT
    |-> HRDATA_OUT[4:0] <= 5'h11) else $error("12h hour out of range");
  hour_24h_a: assert property (rd_r && ad_r == 8'h08 && HOUR_FORMAT_SELECT_OUT
    |-> HRDATA_OUT[5:0] <= 6'h23) else $error("24h hour out of range");
  day_code_a: assert property (rd_r && ad_r == 8'h10 |-> HRDATA_OUT[31:3] == 29'h0 &&
    HRDATA_OUT[2:0] != 3'h7) else $error("bad weekday");
  tick_pulse_a: assert property (TICK_OUT |=> !TICK_OUT)
    else $error("tick longer than one cycle");
  fmt_cause_a: assert property ($changed(HOUR_FORMAT_SELECT_OUT) |->
    $past(wf_r) || $past(wf_r, 2)) else $error("format changed without write");
  cover property (TICK_OUT);
  cover property (wf_r);
  cover property (rd_r && ad_r == 8'h10);
endmodule // rtod_props
bind rtod_regs rtod_props u_rtod_props (
  .SYS_CLK_IN             (SYS_CLK_IN),
  .RST_IN                 (RST_IN),
  .CLK_EN_IN              (CLK_EN_IN),
  .HSEL_IN                (HSEL_IN),
  .HADDR_IN               (HADDR_IN),
  .HTRANS_IN              (HTRANS_IN),
  .HWRITE_IN              (HWRITE_IN),
  .HREADY_IN              (HREADY_IN),
  .HRDATA_OUT             (HRDATA_OUT),
  .HREADYOUT_OUT          (HREADYOUT_OUT),
  .HRESP_OUT              (HRESP_OUT),
  .HOUR_FORMAT_SELECT_OUT (HOUR_FORMAT_SELECT_OUT),
  .TICK_OUT               (TICK_OUT)
);

// ---- tb/rtod_regs_bench.sv ----
// Purpose: Register and rollover tests for rtod_regs
// Assumes: Zero wait states, short tick period
// Notes:   Counts read only while stopped
`timescale 1ns/1ps
`include "rtod_defines.vh"
module rtod_regs_bench;
  reg         clk = 1'b0;
  reg         rst = 1'b1;
  reg         cen = 1'b1;
  reg         hsel = 1'b0;
  reg  [31:0] haddr = 32'h0;
  reg  [1:0]  htrans = 2'b00;
  reg         hwrite = 1'b0;
  reg  [31:0] hwdata = 32'h0;
  reg  [31:0] rv;
  wire [31:0] hrdata;
  wire        hready;
  wire        fmt;
  wire        tick;
  integer     failures = 0;
  integer     n_checks = 0;
  integer     cyc = 0;
  rtod_regs #(.TICK_CYC(8)) u_rtod_regs (
    .SYS_CLK_IN(clk), .RST_IN(rst), .CLK_EN_IN(cen), .HSEL_IN(hsel), .HADDR_IN(haddr),
    .HTRANS_IN(htrans), .HWRITE_IN(hwrite), .HSIZE_IN(3'b010), .HREADY_IN(hready),
    .HWDATA_IN(hwdata), .HRDATA_OUT(hrdata), .HREADYOUT_OUT(hready), .HRESP_OUT(),
    .HOUR_FORMAT_SELECT_OUT(fmt), .TICK_OUT(tick));
  initial forever #12.5 clk = ~clk;
  task complete_run;
    begin
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
    end
  endtask
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 5000) begin
      failures = failures + 1;
      complete_run;
    end
  end
  task chk(input [31:0] seen, input [31:0] exp);
    begin
      n_checks = n_checks + 1;
      if (seen !== exp) begin
        failures = failures + 1;
        $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task xfer(input [3:0] idx, input w, input [31:0] d);
    begin
      hsel <= 1'b1;
      haddr <= {26'h0, idx, 2'b00};
      htrans <= 2'b10;
      hwrite <= w;
      @(posedge clk);
      while (hready !== 1'b1) @(posedge clk);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      @(posedge clk);
      while (hready !== 1'b1) @(posedge clk);
      rv = hrdata;
    end
  endtask
  task rd(input [3:0] idx, input [31:0] exp);
    begin
      xfer(idx, 1'b0, 32'h0);
      chk(rv, exp);
    end
  endtask
  // Set format and time, run until one tick, stop, read back
  task run_case(input f, input [7:0] s, m, h, d, es, em, eh, ed);
    begin
      xfer(`RTOD_IDX_CTRL, 1'b1, 32'h1);
      xfer(`RTOD_IDX_FMT, 1'b1, {31'h0, f});
      rd(`RTOD_IDX_FMT, {31'h0, f});
      chk(fmt, f);
      xfer(`RTOD_IDX_CTRL, 1'b1, 32'h0);
      xfer(`RTOD_IDX_SEC, 1'b1, {24'h0, s});
      xfer(`RTOD_IDX_MIN, 1'b1, {24'h0, m});
      xfer(`RTOD_IDX_HOUR, 1'b1, {24'h0, h});
      xfer(`RTOD_IDX_DAY, 1'b1, {24'h0, d});
      xfer(`RTOD_IDX_CTRL, 1'b1, 32'h8);
      while (tick !== 1'b1) @(posedge clk);
      xfer(`RTOD_IDX_CTRL, 1'b1, 32'h0);
      rd(`RTOD_IDX_SEC, es);
      rd(`RTOD_IDX_MIN, em);
      rd(`RTOD_IDX_HOUR, eh);
      rd(`RTOD_IDX_DAY, ed);
    end
  endtask
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(4'h3, 32'h0);
    rd(`RTOD_IDX_FMT, 32'h0);
    run_case(1'b1, 8'hd9, 8'hd9, 8'h23, 8'h06, 8'h00, 8'h00, 8'h00, 8'h00);
    run_case(1'b0, 8'h59, 8'h59, 8'h31, 8'h03, 8'h00, 8'h00, 8'h00, 8'h04);
    run_case(1'b0, 8'h59, 8'h59, 8'h11, 8'h02, 8'h00, 8'h00, 8'h20, 8'h02);
    run_case(1'b1, 8'h09, 8'h12, 8'h05, 8'h01, 8'h10, 8'h12, 8'h05, 8'h01);
    xfer(`RTOD_IDX_CTRL, 1'b1, 32'h1);
    xfer(`RTOD_IDX_SEC, 1'b1, 32'h33);
    rd(`RTOD_IDX_SEC, 32'h0);
    xfer(`RTOD_IDX_CTRL, 1'b1, 32'h0);
    rd(`RTOD_IDX_SEC, 32'h10);
    xfer(`RTOD_IDX_CTRL, 1'b1, 32'h8);
    // Clock enable low freezes the prescaler
    cen <= 1'b0;
    repeat (20) begin
      @(posedge clk);
      chk(tick, 32'h0);
    end
    cen <= 1'b1;
    while (tick !== 1'b1) @(posedge clk);
    xfer(`RTOD_IDX_CTRL, 1'b1, 32'h0);
    rd(`RTOD_IDX_SEC, 32'h11);
    rd(`RTOD_IDX_SEC, 32'h11);
    complete_run;
  end
endmodule // rtod_regs_bench
